// [signal_noise_detector.v]
// signal (squelch) and fsk noise detector with its two configuration sets, behind an axi4-lite slave
// assumes raw quality and fsk noise values arrive synchronous to mclk_in with a sample strobe
//
// Overview of operation
// - mode field picks squelch, noise, both, or squelch with low-qualified noise
// - bits 7:6 give consecutive-sample count for detect; 00b disables counting
// - run-mode threshold is bits 5:0 of the run threshold register
// - wake-up threshold is bits 5:0 of the wake threshold register
// - readout select bit 7 routes low-threshold signal level onto quality status
// - bit 6 picks main range factor from data rate (0) or from select register (1); low range factor always from select register
// - low range factor code 00..11 selects 2,4,6,8; reset 6
// - main range factor code 00..11 selects 4,6,8,10; reset 8
// - quality value is divided by two to the range factor before use
// - in qualified mode noise detect counts only while level exceeds low threshold
// - higher quality value means more reliable bit; used to separate data from noise
`timescale 1ns/1ps
`include "sig_noise_det_map.vh"

module signal_noise_detector (
  input wire mclk_in,
  input wire rst_in,
  input wire ce_in,
  // axi4-lite slave
  input wire [9:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [9:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // detector side
  input wire sample_valid_in,
  input wire [15:0] bit_quality_value_in,
  input wire [7:0] fsk_noise_value_in,
  input wire config_set_b_in,
  input wire wake_mode_in,
  input wire [1:0] data_rate_range_in,
  output reg signal_detect_out,
  output reg [7:0] quality_status_out
);

  // ----------------------------------------
  // decoding functions
  // ----------------------------------------
  // main range code to shift count
  function [3:0] main_shift;
    input [1:0] code;
    begin
      case (code)
        2'b00: main_shift = 4'h4;
        2'b01: main_shift = 4'h6;
        2'b10: main_shift = 4'h8;
        default: main_shift = 4'ha;
      endcase
    end
  endfunction

  // low range code to shift count
  function [3:0] low_shift;
    input [1:0] code;
    begin
      case (code)
        2'b00: low_shift = 4'h2;
        2'b01: low_shift = 4'h4;
        2'b10: low_shift = 4'h6;
        default: low_shift = 4'h8;
      endcase
    end
  endfunction

  // saturate a scaled value onto the 8-bit readout
  function [7:0] sat8;
    input [15:0] v;
    begin
      sat8 = (v[15:8] != 8'h00) ? 8'hff : v[7:0];
    end
  endfunction

  // ----------------------------------------
  // configuration storage, index 0 = set a, 1 = set b
  // ----------------------------------------
  reg [7:0] run_thr [0:1];
  reg [7:0] wake_thr [0:1];
  reg [7:0] noise_cfg [0:1];
  reg [7:0] low_thr [0:1];
  reg [7:0] range_sel [0:1];
  reg [7:0] noise_thr [0:1];

  // ----------------------------------------
  // axi write path
  // ----------------------------------------
  reg aw_full;
  reg w_full;
  reg [7:0] aw_index;
  reg [7:0] w_byte;
  reg w_lane0;
  wire do_write;
  wire aw_hit;

  // ready low while frozen, so no handshake completes unseen
  assign s_axi_awready_out = ~aw_full & ce_in;
  assign s_axi_wready_out = ~w_full & ce_in;
  // both halves held and the previous response gone
  assign do_write = aw_full & w_full & ~s_axi_bvalid_out;

  function idx_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_A_RUN_THR, `IDX_A_WAKE_THR, `IDX_A_NOISE_CFG,
        `IDX_B_RUN_THR, `IDX_B_WAKE_THR, `IDX_B_NOISE_CFG,
        `IDX_A_LOW_THR, `IDX_B_LOW_THR, `IDX_A_RANGE_SEL,
        `IDX_B_RANGE_SEL, `IDX_A_NOISE_THR, `IDX_B_NOISE_THR,
        `IDX_STATUS: idx_mapped = 1'b1;
        default: idx_mapped = 1'b0;
      endcase
    end
  endfunction

  assign aw_hit = idx_mapped(aw_index) & (aw_index != `IDX_STATUS);

  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_index <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end
    else if (ce_in)
    begin
      if (s_axi_awvalid_in && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_index <= s_axi_awaddr_in[9:2];
      end
      if (s_axi_wvalid_in && !w_full)
      begin
        w_full <= 1'b1;
        w_byte <= s_axi_wdata_in[7:0];
        w_lane0 <= s_axi_wstrb_in[0];
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= aw_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // register file, one generate copy per configuration set
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1)
    begin : cfg_set
      wire wr_en;
      wire [7:0] base_run;
      assign wr_en = do_write & w_lane0;
      assign base_run = (gs == 0) ? `IDX_A_RUN_THR : `IDX_B_RUN_THR;
      always @(posedge mclk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          run_thr[gs] <= `RST_RUN_THR;
          wake_thr[gs] <= `RST_WAKE_THR;
          noise_cfg[gs] <= `RST_NOISE_CFG;
          low_thr[gs] <= `RST_LOW_THR;
          range_sel[gs] <= `RST_RANGE_SEL;
          noise_thr[gs] <= `RST_NOISE_THR;
        end
        else if (ce_in && wr_en)
        begin
          if (aw_index == base_run)
            run_thr[gs] <= w_byte;
          if (aw_index == base_run + 8'h01)
            wake_thr[gs] <= w_byte;
          if (aw_index == ((gs == 0) ? `IDX_A_NOISE_CFG : `IDX_B_NOISE_CFG))
            noise_cfg[gs] <= w_byte;
          if (aw_index == ((gs == 0) ? `IDX_A_LOW_THR : `IDX_B_LOW_THR))
            low_thr[gs] <= w_byte;
          if (aw_index == ((gs == 0) ? `IDX_A_RANGE_SEL : `IDX_B_RANGE_SEL))
            range_sel[gs] <= w_byte;
          if (aw_index == ((gs == 0) ? `IDX_A_NOISE_THR : `IDX_B_NOISE_THR))
            noise_thr[gs] <= w_byte;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // detector datapath
  // ----------------------------------------
  wire set_idx;
  wire [7:0] active_thr_reg;
  wire [5:0] active_thr;
  wire [1:0] cnt_setting;
  wire [1:0] mode;
  wire [3:0] shift_main;
  wire [3:0] shift_low;
  wire [15:0] scaled_main;
  wire [15:0] scaled_low;
  wire squelch_hit;
  wire low_hit;
  wire noise_hit;
  reg squelch_ok;
  reg noise_ok;
  reg next_detect;
  reg [1:0] run_count;
  reg [1:0] next_count;

  assign set_idx = config_set_b_in;
  assign active_thr_reg = wake_mode_in ? wake_thr[set_idx] : run_thr[set_idx];
  assign active_thr = active_thr_reg[`F_THR_HI:`F_THR_LO];
  assign cnt_setting = active_thr_reg[`F_CNT_HI:`F_CNT_LO];
  assign mode = noise_cfg[set_idx][`F_MODE_HI:`F_MODE_LO];

  // manual range or data-rate derived range
  assign shift_main = range_sel_manual(low_thr[set_idx]) ?
                      main_shift(range_sel[set_idx][`F_RANGE_HI:`F_RANGE_LO]) :
                      main_shift(data_rate_range_in);
  assign shift_low = low_shift(range_sel[set_idx][`F_LOW_RANGE_HI:`F_LOW_RANGE_LO]);

  function range_sel_manual;
    input [7:0] r;
    begin
      range_sel_manual = r[`F_MANUAL_RANGE];
    end
  endfunction

  assign scaled_main = bit_quality_value_in >> shift_main;
  assign scaled_low = bit_quality_value_in >> shift_low;

  // larger quality means a more trustworthy bit
  assign squelch_hit = scaled_main > {10'h000, active_thr};
  assign low_hit = scaled_low > {10'h000, low_thr[set_idx][`F_THR_HI:`F_THR_LO]};
  // noise falls when a real carrier is present, so below threshold means signal
  assign noise_hit = fsk_noise_value_in < noise_thr[set_idx];

  // consecutive-sample qualification of the squelch result
  always @*
  begin
    next_count = run_count;
    squelch_ok = 1'b0;
    if (!squelch_hit)
      next_count = 2'b00;
    else if (cnt_setting == 2'b00)
      squelch_ok = 1'b1;
    else
    begin
      if (run_count != cnt_setting)
        next_count = run_count + 2'b01;
      squelch_ok = (run_count + 2'b01 >= cnt_setting) || (run_count == cnt_setting);
    end
  end

  always @*
  begin
    noise_ok = noise_hit;
    case (mode)
      `MODE_SQUELCH: next_detect = squelch_ok;
      `MODE_NOISE: next_detect = noise_hit;
      `MODE_BOTH: next_detect = squelch_ok & noise_hit;
      `MODE_QUALIFIED:
      begin
        noise_ok = noise_hit & low_hit;
        next_detect = squelch_ok & noise_ok;
      end
      default: next_detect = squelch_ok;
    endcase
  end

  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      run_count <= 2'b00;
      signal_detect_out <= 1'b0;
      quality_status_out <= 8'h00;
    end
    else if (ce_in && sample_valid_in)
    begin
      run_count <= next_count;
      signal_detect_out <= next_detect;
      // calibration readout shows the level seen by the low threshold
      quality_status_out <= low_thr[set_idx][`F_READOUT_SEL] ? sat8(scaled_low) : sat8(scaled_main);
    end
  end

  // ----------------------------------------
  // axi read path
  // ----------------------------------------
  wire [7:0] ar_index;
  assign ar_index = s_axi_araddr_in[9:2];
  assign s_axi_arready_out = ~s_axi_rvalid_out & ce_in;

  // configuration registers are write-only and read as zero
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `RESP_OKAY;
    end
    else if (ce_in)
    begin
      if (s_axi_arvalid_in && !s_axi_rvalid_out)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= idx_mapped(ar_index) ? `RESP_OKAY : `RESP_SLVERR;
        if (ar_index == `IDX_STATUS)
          s_axi_rdata_out <= {21'h00_0000, noise_ok, squelch_ok, signal_detect_out, quality_status_out};
        else
          s_axi_rdata_out <= 32'h0000_0000;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // signal_noise_detector

// [sig_noise_det_map.vh]
// register indices, field positions, reset values and codes of the signal and noise detector
// assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus
`ifndef SIG_NOISE_DET_MAP_VH
`define SIG_NOISE_DET_MAP_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_A_RUN_THR 8'h71
`define IDX_A_WAKE_THR 8'h72
`define IDX_A_NOISE_CFG 8'h81
`define IDX_B_RUN_THR 8'h91
`define IDX_B_WAKE_THR 8'h92
`define IDX_B_NOISE_CFG 8'ha1
`define IDX_A_LOW_THR 8'hb6
`define IDX_B_LOW_THR 8'hb7
`define IDX_A_RANGE_SEL 8'hb8
`define IDX_B_RANGE_SEL 8'hb9
`define IDX_A_NOISE_THR 8'hc0
`define IDX_B_NOISE_THR 8'hc1
`define IDX_STATUS 8'hc2

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_RUN_THR 8'h00
`define RST_WAKE_THR 8'h00
`define RST_NOISE_CFG 8'h00
`define RST_LOW_THR 8'h00
`define RST_RANGE_SEL 8'h0a
`define RST_NOISE_THR 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define F_CNT_HI 7
`define F_CNT_LO 6
`define F_THR_HI 5
`define F_THR_LO 0
`define F_MODE_HI 5
`define F_MODE_LO 4
`define F_READOUT_SEL 7
`define F_MANUAL_RANGE 6
`define F_LOW_RANGE_HI 3
`define F_LOW_RANGE_LO 2
`define F_RANGE_HI 1
`define F_RANGE_LO 0

// ----------------------------------------
// detection modes
// ----------------------------------------
`define MODE_SQUELCH 2'b00
`define MODE_NOISE 2'b01
`define MODE_BOTH 2'b10
`define MODE_QUALIFIED 2'b11

// ----------------------------------------
// axi responses
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [sig_noise_det_monitor.sv]
// checker of the axi handshakes and detector update timing at the detector's ports
// assumes it is bound into signal_noise_detector, one clock domain on mclk_in
`timescale 1ns/1ps
module sig_noise_det_monitor (
  input wire mclk_in,
  input wire rst_in,
  input wire ce_in,
  input wire sample_valid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wready_out,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire signal_detect_out,
  input wire [7:0] quality_status_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire samp = ce_in & sample_valid_in;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  bvalid_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  read_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken while data pending");
  bvalid_cause_a: assert property ($rose(s_axi_bvalid_out) |-> !$past(s_axi_awready_out) && !$past(s_axi_wready_out))
    else $error("write response without address and data");
  rvalid_cause_a: assert property ($rose(s_axi_rvalid_out) |-> $past(s_axi_arvalid_in) && $past(s_axi_arready_out))
    else $error("read data without address");
  detect_moment_a: assert property ($changed(signal_detect_out) |-> $past(samp))
    else $error("detect changed without a sample");
  status_moment_a: assert property ($changed(quality_status_out) |-> $past(samp))
    else $error("status changed without a sample");
  reset_idle_a: assert property (disable iff (1'b0) rst_in |-> !signal_detect_out && quality_status_out == 8'h00)
    else $error("outputs not idle in reset");
endmodule // sig_noise_det_monitor

bind signal_noise_detector sig_noise_det_monitor sig_noise_det_monitor_i (.mclk_in(mclk_in), .rst_in(rst_in),
  .ce_in(ce_in), .sample_valid_in(sample_valid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .signal_detect_out(signal_detect_out), .quality_status_out(quality_status_out));

// [testbench.sv]
// self-checking bench for the signal and noise detector behind axi4-lite
// assumes a one-deep axi4-lite slave; ready outputs combinational as handed over
`timescale 1ns/1ps
`include "sig_noise_det_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  reg mclk_in = 0;
  reg rst_in = 0;
  reg awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, sv = 0, setb = 0, wake = 0, ce = 1;
  reg [3:0] strb = 4'hf;
  reg [9:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  reg [15:0] q = 0;
  reg [7:0] fsk = 8'hff;
  reg [1:0] rate = 0;
  wire awready, wready, bvalid, arready, rvalid, det;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] qstat;
  integer n_fail = 0, comparisons = 0, cycles = 0, i, m;
  reg [31:0] rd_val;
  reg [1:0] rd_resp;
  reg got_det;
  reg [7:0] got_q;
  reg [3:0] sh;
  real r, mean, sum = 0.0, sq = 0.0, fsum = 0.0, fsq = 0.0;
  integer thr, c;
  reg [1:0] md [0:6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  reg [15:0] qv [0:6] = '{16'h0020, 16'h0000, 16'h0180, 16'h0180, 16'h0180, 16'h0020, 16'h0180};
  reg [7:0] fv [0:6] = '{8'hff, 8'h10, 8'hff, 8'hff, 8'h10, 8'h10, 8'h10};
  reg ex [0:6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  signal_noise_detector signal_noise_detector_i (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .sample_valid_in(sv), .bit_quality_value_in(q), .fsk_noise_value_in(fsk),
    .config_set_b_in(setb), .wake_mode_in(wake), .data_rate_range_in(rate), .signal_detect_out(det),
    .quality_status_out(qstat));

  initial forever #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  // ----------------------------------------
  // bus and sample tasks
  // ----------------------------------------
  task finish_test;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // bready held low at first so the response has to stand
  task wr(input [7:0] a, input [7:0] d, input [1:0] er);
    reg ta, tw;
    begin
      awaddr <= {a, 2'b00};
      wdata <= {24'h00_0000, d};
      awv <= 1;
      wv <= 1;
      forever
      begin
        @(negedge mclk_in);
        if (!awv && !wv) break;
        ta = awv && awready;
        tw = wv && wready;
        @(posedge mclk_in);
        if (ta) awv <= 0;
        if (tw) wv <= 0;
      end
      while (!bvalid) @(negedge mclk_in);
      @(posedge mclk_in);
      bready <= 1;
      @(negedge mclk_in);
      `CHK(bresp, er)
      @(posedge mclk_in);
      bready <= 0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      araddr <= {a, 2'b00};
      arv <= 1;
      @(negedge mclk_in);
      while (!arready) @(negedge mclk_in);
      @(posedge mclk_in);
      arv <= 0;
      @(negedge mclk_in);
      while (!rvalid) @(negedge mclk_in);
      @(posedge mclk_in);
      rready <= 1;
      @(negedge mclk_in);
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge mclk_in);
      rready <= 0;
    end
  endtask
  task samp(input [15:0] v, input [7:0] f);
    begin
      q <= v;
      fsk <= f;
      sv <= 1;
      @(posedge mclk_in);
      sv <= 0;
      repeat (3) @(posedge mclk_in);
      @(negedge mclk_in);
      got_det = det;
      got_q = qstat;
      @(posedge mclk_in);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_access;
    begin
      `CHK(qstat, 8'h00)
      rd(`IDX_A_RUN_THR);
      `CHK(rd_val, 32'h0000_0000)
      `CHK(rd_resp, `RESP_OKAY)
      rd(8'h00);
      `CHK(rd_resp, `RESP_SLVERR)
      wr(8'h00, 8'h55, `RESP_SLVERR);
      wr(`IDX_STATUS, 8'h55, `RESP_SLVERR);
      wr(`IDX_A_LOW_THR, 8'h40, `RESP_OKAY);
      samp(16'h3500, 8'hff);
      `CHK(got_q, 8'h35)
      strb <= 4'h0;
      wr(`IDX_A_LOW_THR, 8'hc0, `RESP_OKAY);
      strb <= 4'hf;
      samp(16'h3500, 8'hff);
      `CHK(got_q, 8'h35)
      wr(`IDX_A_LOW_THR, 8'hc0, `RESP_OKAY);
      samp(16'h0d40, 8'hff);
      `CHK(got_q, 8'h35)
    end
  endtask
  // manual main, manual low readout, then automatic from the data rate
  task s_range;
    for (m = 0; m < 3; m++)
      for (i = 0; i < 4; i++)
      begin
        wr(`IDX_A_RANGE_SEL, {4'h0, i[1:0], i[1:0]}, `RESP_OKAY);
        wr(`IDX_A_LOW_THR, (m == 0) ? 8'h40 : (m == 1) ? 8'hc0 : 8'h00, `RESP_OKAY);
        rate <= (m == 2) ? i[1:0] : ~i[1:0];
        sh = (m == 1) ? 2 + 2 * i : 4 + 2 * i;
        samp(16'h0035 << sh, 8'hff);
        `CHK(got_q, 8'h35)
      end
  endtask
  task s_thresh;
    begin
      wr(`IDX_A_RANGE_SEL, 8'h00, `RESP_OKAY);
      wr(`IDX_A_LOW_THR, 8'h40, `RESP_OKAY);
      wr(`IDX_A_RUN_THR, 8'h10, `RESP_OKAY);
      wr(`IDX_A_WAKE_THR, 8'h20, `RESP_OKAY);
      samp(16'h0180, 8'hff);
      `CHK(got_det, 1'b1)
      rd(`IDX_STATUS);
      `CHK(rd_val, 32'h0000_0318)
      samp(16'h0100, 8'hff);
      `CHK(got_det, 1'b0)
      wake <= 1;
      samp(16'h0180, 8'hff);
      `CHK(got_det, 1'b0)
      samp(16'h0210, 8'hff);
      `CHK(got_det, 1'b1)
      wake <= 0;
      wr(`IDX_A_RUN_THR, 8'h90, `RESP_OKAY);
      samp(16'h0100, 8'hff);
      samp(16'h0180, 8'hff);
      `CHK(got_det, 1'b0)
      samp(16'h0180, 8'hff);
      `CHK(got_det, 1'b1)
      setb <= 1;
      rate <= 2'h0;
      samp(16'h0180, 8'hff);
      `CHK(got_det, 1'b1)
      wr(`IDX_B_RUN_THR, 8'h3f, `RESP_OKAY);
      samp(16'h0180, 8'hff);
      `CHK(got_det, 1'b0)
      setb <= 0;
    end
  endtask
  task s_mode;
    begin
      wr(`IDX_A_RANGE_SEL, 8'h00, `RESP_OKAY);
      wr(`IDX_A_RUN_THR, 8'h01, `RESP_OKAY);
      wr(`IDX_A_LOW_THR, 8'h7f, `RESP_OKAY);
      wr(`IDX_A_NOISE_THR, 8'h40, `RESP_OKAY);
      for (i = 0; i < 7; i++)
      begin
        wr(`IDX_A_NOISE_CFG, {2'h0, md[i], 4'h7}, `RESP_OKAY);
        samp(qv[i], fv[i]);
        `CHK(got_det, ex[i])
      end
    end
  endtask

  // noise-only statistics give the signal and the noise threshold
  task s_stats;
    begin
      for (i = 0; i < 500; i++)
      begin
        samp(i[0] ? 16'h00c0 : 16'h0080, i[0] ? 8'h38 : 8'h30);
        `CHK(got_q, i[0] ? 8'h0c : 8'h08)
        r = got_q;
        sum += r;
        sq += r * r;
        r = fsk;
        fsum += r;
        fsq += r * r;
      end
      mean = sum / 500.0;
      thr = $rtoi(mean + 2.0 * $sqrt(sq / 500.0 - mean * mean) + 0.5);
      wr(`IDX_A_RUN_THR, {2'b00, thr[5:0]}, `RESP_OKAY);
      samp(16'h00e0, 8'hff);
      `CHK(got_det, 1'b0)
      samp(16'h00f0, 8'hff);
      `CHK(got_det, 1'b1)
      mean = fsum / 500.0;
      thr = $rtoi(mean - $sqrt(fsq / 500.0 - mean * mean) + 0.5);
      wr(`IDX_A_NOISE_THR, thr[7:0], `RESP_OKAY);
      wr(`IDX_A_NOISE_CFG, 8'h17, `RESP_OKAY);
      samp(16'h0000, 8'h2f);
      `CHK(got_det, 1'b1)
      samp(16'h0000, 8'h30);
      `CHK(got_det, 1'b0)
    end
  endtask
  // low threshold calibrated on the routed low-threshold level
  task s_calib;
    begin
      wr(`IDX_A_LOW_THR, 8'hc0, `RESP_OKAY);
      mean = 999.0;
      for (c = 0; c < 4 && mean >= 50.0; c++)
      begin
        wr(`IDX_A_RANGE_SEL, {4'h0, c[1:0], 2'b00}, `RESP_OKAY);
        sum = 0.0;
        sq = 0.0;
        for (i = 0; i < 8; i++)
        begin
          samp(16'h0a00, 8'h10);
          `CHK(got_q, c == 0 ? 8'hff : c == 1 ? 8'ha0 : 8'h28)
          r = got_q;
          sum += r;
          sq += r * r;
        end
        mean = sum / 8.0;
      end
      `CHK(c[2:0], 3'h3)
      thr = $rtoi(0.8 * (mean - 3.0 * $sqrt(sq / 8.0 - mean * mean)) + 0.5);
      wr(`IDX_A_LOW_THR, {2'b01, thr[5:0]}, `RESP_OKAY);
      samp(16'h0a00, 8'h10);
      `CHK(got_q, 8'ha0)
      wr(`IDX_A_NOISE_CFG, 8'h37, `RESP_OKAY);
      samp(16'h0a00, 8'h10);
      `CHK(got_det, 1'b1)
      samp(16'h0800, 8'h10);
      `CHK(got_det, 1'b0)
    end
  endtask
  // a sample while disabled must leave the outputs of the last one
  task s_freeze;
    begin
      ce <= 1'b0;
      samp(16'h0000, 8'hff);
      `CHK(got_det, 1'b1)
      `CHK(got_q, 8'h18)
      ce <= 1'b1;
    end
  endtask

  initial
  begin
    rst_in <= 1;
    repeat (5) @(posedge mclk_in);
    rst_in <= 0;
    @(posedge mclk_in);
    s_access;
    s_range;
    s_thresh;
    s_stats;
    s_calib;
    s_mode;
    s_freeze;
    finish_test;
  end
endmodule // testbench
